// file: idt_decoder.sv
// Behaviour
// - Double-word instructions combine two 24-bit words into one 48-bit encoding.
// - The second word must carry zero in its top eight bits.
// - A second word executed alone acts as a no-operation.
// - Every double-word instruction completes in exactly two cycles.
// - Single-word takes one cycle, more on true test, branch, window/table or register read.
// - Extra cycles beyond the first are filled with no-operation cycles.
// - A performed skip takes two cycles over single words, three over doubles.
// - A double-word data move takes two cycles.
// - Bit position field is four bits selecting bit zero to fifteen.
// - File register address covers 0x0000 to 0x1fff.
// - Writeback goes to W13 or to memory at W13, then W13 plus two.
// - Result choice selects accumulator A or B.
// - Keep carry, digit carry, negative, overflow and sticky zero flags.
// - Keep overflow and saturation flags for each accumulator.
// - Ten-bit literal spans 0..255 in byte size and 0..1023 in word size.
// - Program address literal must have a zero least significant bit.
// - Signed ten-bit literal is sign-extended over -512 to 511.
// - Base register selects any of W0 to W15.
// - Destination supports direct, indirect, post/pre inc/dec and base offset.
// - Size suffix selects byte, word or double word, word by default.
`timescale 1ns/1ns
`include "idt_defines.svh"
module idt_decoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fetch_valid,
  input wire logic [23:0] fetch_word,
  output logic fetch_ready,
  input wire logic cond_true,
  input wire logic skip_test,
  input wire logic alu_upd,
  input wire logic alu_carry,
  input wire logic alu_digit_carry,
  input wire logic alu_negative,
  input wire logic alu_signed_wrap,
  input wire logic alu_zero,
  input wire logic alu_sticky_z,
  input wire logic acc_a_ovf,
  input wire logic acc_b_ovf,
  input wire logic acc_a_sat,
  input wire logic acc_b_sat,
  output logic dec_valid,
  output idt_pkg::idt_class_t dec_class,
  output idt_pkg::idt_size_t dec_size,
  output logic [15:0] dec_lit,
  output logic [12:0] dec_file_addr,
  output logic [3:0] dec_bit_pos,
  output logic [3:0] dec_base_reg,
  output logic [3:0] dec_dst_reg,
  output idt_pkg::idt_mode_t dec_dst_mode,
  output logic dec_acc_sel,
  output logic dec_wb_ind,
  output logic [2:0] dec_w13_step,
  output logic [22:0] dec_prog_addr,
  output logic dec_invalid,
  output logic pc_load,
  output logic nop_fill,
  output logic retire,
  output idt_pkg::idt_class_t retire_class,
  output logic [1:0] retire_cycles
);
  import idt_pkg::*;

  // ****************************************************************
  // Field decode and status flags
  // ****************************************************************
  idt_top_t s_r;
  idt_top_t s_nxt;
  idt_flag_t flags;
  logic [23:0] fld_w1;
  logic fld_second;
  idt_class_t f_cls;
  logic f_dbl;
  idt_size_t f_size;
  logic [15:0] f_lit;
  logic [12:0] f_file;
  logic [3:0] f_bit;
  logic [3:0] f_breg;
  logic [3:0] f_dreg;
  idt_mode_t f_mode;
  logic f_acc;
  logic f_wb;
  logic [22:0] f_padr;
  logic f_inv;
  logic take;
  logic setup;
  logic access;
  logic mapped;
  logic extra;
  logic [3:0] dsp_clr;

  assign fld_second = (s_r.st == st_second);
  assign fld_w1 = fld_second ? s_r.w1 : fetch_word;

  idt_fields u_fields (
    .w1(fld_w1),
    .w2(fetch_word),
    .second(fld_second),
    .cls(f_cls),
    .dbl(f_dbl),
    .size(f_size),
    .lit(f_lit),
    .file_addr(f_file),
    .bit_pos(f_bit),
    .base_reg(f_breg),
    .dst_reg(f_dreg),
    .dst_mode(f_mode),
    .acc_sel(f_acc),
    .wb_ind(f_wb),
    .prog_addr(f_padr),
    .invalid(f_inv)
  );

  idt_flags u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .alu_upd(alu_upd),
    .alu_carry(alu_carry),
    .alu_digit_carry(alu_digit_carry),
    .alu_negative(alu_negative),
    .alu_signed_wrap(alu_signed_wrap),
    .alu_zero(alu_zero),
    .alu_sticky_z(alu_sticky_z),
    .acc_a_ovf(acc_a_ovf),
    .acc_b_ovf(acc_b_ovf),
    .acc_a_sat(acc_a_sat),
    .acc_b_sat(acc_b_sat),
    .dsp_clr(dsp_clr),
    .flags(flags)
  );

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign mapped = (paddr == `IDT_OFS_CTRL) || (paddr == `IDT_OFS_STATUS)
    || (paddr == `IDT_OFS_COUNT) || (paddr == `IDT_OFS_LAST);
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign dsp_clr = (access && pwrite && (paddr == `IDT_OFS_STATUS)) ?
    pwdata[`IDT_STAT_DSP_HI:`IDT_STAT_DSP_LO] : 4'h0;

  // ****************************************************************
  // Fetch, decode and cycle sequencing
  // ****************************************************************
  // The pipeline only stalls for whole NOP cycles, so a fill cycle refuses fetch.
  assign fetch_ready = s_r.en && (s_r.st != st_fill);
  assign take = fetch_valid && fetch_ready;

  // Special register reads sit below the limit; window reads cost only when enabled.
  assign extra = ((f_cls == cl_bra) && cond_true)
    || (f_cls == cl_tblrd)
    || (f_cls == cl_movd)
    || ((f_cls == cl_filerd) && (f_file < `IDT_SPECIAL_LIMIT))
    || ((f_cls == cl_psvrd) && s_r.win_en);

  always_comb begin
    s_nxt = s_r;
    s_nxt.dec_valid = 1'b0;
    s_nxt.pc_load = 1'b0;
    s_nxt.nop_fill = 1'b0;
    s_nxt.retire = 1'b0;
    if (setup && !pwrite) begin
      unique case (paddr)
        `IDT_OFS_CTRL: s_nxt.prdata = {30'h0, s_r.win_en, s_r.en};
        `IDT_OFS_STATUS: s_nxt.prdata = {23'h0, flags};
        `IDT_OFS_COUNT: s_nxt.prdata = {16'h0, s_r.instr_cnt};
        `IDT_OFS_LAST: s_nxt.prdata = {25'h0, s_r.dec_invalid, s_r.ret_class, s_r.ret_cycles};
        default: s_nxt.prdata = 32'h0;
      endcase
    end
    if (access && pwrite && (paddr == `IDT_OFS_CTRL)) begin
      s_nxt.en = pwdata[`IDT_CTRL_EN_BIT];
      s_nxt.win_en = pwdata[`IDT_CTRL_WIN_BIT];
    end
    unique case (s_r.st)
      st_fetch: begin
        if (take && s_r.skip_pend) begin
          // A swallowed word costs one NOP cycle; a double opcode drags its tail along.
          s_nxt.nop_fill = 1'b1;
          s_nxt.skip_cnt = 2'(s_r.skip_cnt + 2'h1);
          s_nxt.skip_pend = f_dbl;
          if (!f_dbl) begin
            s_nxt.retire = 1'b1;
            s_nxt.ret_class = cl_skip;
            s_nxt.ret_cycles = 2'(s_r.skip_cnt + 2'h1);
            s_nxt.instr_cnt = 16'(s_r.instr_cnt + 16'h1);
          end
        end else if (take && f_dbl) begin
          s_nxt.w1 = fetch_word;
          s_nxt.st = st_second;
        end else if (take) begin
          s_nxt.dec_valid = 1'b1;
          s_nxt.dec_class = f_cls;
          s_nxt.dec_size = f_size;
          s_nxt.dec_lit = f_lit;
          s_nxt.dec_file_addr = f_file;
          s_nxt.dec_bit_pos = f_bit;
          s_nxt.dec_base_reg = f_breg;
          s_nxt.dec_dst_reg = f_dreg;
          s_nxt.dec_dst_mode = f_mode;
          s_nxt.dec_acc_sel = f_acc;
          s_nxt.dec_wb_ind = f_wb;
          s_nxt.dec_w13_step = ((f_cls == cl_mac) && f_wb) ? `IDT_W13_STEP : 3'h0;
          s_nxt.dec_prog_addr = 23'h0;
          s_nxt.dec_invalid = f_inv;
          if ((f_cls == cl_skip) && skip_test && !f_inv) begin
            s_nxt.skip_pend = 1'b1;
            s_nxt.skip_cnt = `IDT_CYC_ONE;
          end else if (extra && !f_inv) begin
            s_nxt.pend_class = f_cls;
            s_nxt.nop_fill = 1'b1;
            s_nxt.st = st_fill;
          end else begin
            s_nxt.retire = 1'b1;
            s_nxt.ret_class = f_cls;
            s_nxt.ret_cycles = `IDT_CYC_ONE;
            s_nxt.instr_cnt = 16'(s_r.instr_cnt + 16'h1);
          end
        end
      end
      st_second: begin
        if (take) begin
          s_nxt.dec_valid = 1'b1;
          s_nxt.dec_class = f_cls;
          s_nxt.dec_size = f_size;
          s_nxt.dec_lit = f_lit;
          s_nxt.dec_file_addr = f_file;
          s_nxt.dec_bit_pos = f_bit;
          s_nxt.dec_base_reg = f_breg;
          s_nxt.dec_dst_reg = f_dreg;
          s_nxt.dec_dst_mode = f_mode;
          s_nxt.dec_acc_sel = f_acc;
          s_nxt.dec_wb_ind = f_wb;
          s_nxt.dec_w13_step = 3'h0;
          s_nxt.dec_prog_addr = f_padr;
          s_nxt.dec_invalid = f_inv;
          s_nxt.pc_load = !f_inv;
          s_nxt.retire = 1'b1;
          s_nxt.ret_class = f_cls;
          s_nxt.ret_cycles = `IDT_CYC_TWO;
          s_nxt.instr_cnt = 16'(s_r.instr_cnt + 16'h1);
          s_nxt.st = st_fetch;
        end
      end
      st_fill: begin
        s_nxt.retire = 1'b1;
        s_nxt.ret_class = s_r.pend_class;
        s_nxt.ret_cycles = `IDT_CYC_TWO;
        s_nxt.instr_cnt = 16'(s_r.instr_cnt + 16'h1);
        s_nxt.st = st_fetch;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.st <= st_fetch;
      s_r.en <= `IDT_CTRL_EN_RST;
      s_r.win_en <= `IDT_CTRL_WIN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign dec_valid = s_r.dec_valid;
  assign dec_class = s_r.dec_class;
  assign dec_size = s_r.dec_size;
  assign dec_lit = s_r.dec_lit;
  assign dec_file_addr = s_r.dec_file_addr;
  assign dec_bit_pos = s_r.dec_bit_pos;
  assign dec_base_reg = s_r.dec_base_reg;
  assign dec_dst_reg = s_r.dec_dst_reg;
  assign dec_dst_mode = s_r.dec_dst_mode;
  assign dec_acc_sel = s_r.dec_acc_sel;
  assign dec_wb_ind = s_r.dec_wb_ind;
  assign dec_w13_step = s_r.dec_w13_step;
  assign dec_prog_addr = s_r.dec_prog_addr;
  assign dec_invalid = s_r.dec_invalid;
  assign pc_load = s_r.pc_load;
  assign nop_fill = s_r.nop_fill;
  assign retire = s_r.retire;
  assign retire_class = s_r.ret_class;
  assign retire_cycles = s_r.ret_cycles;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_double_two_cycles: assert property (@(posedge pclk) disable iff (!presetn)
    (retire && ((retire_class == cl_goto) || (retire_class == cl_call)))
      |-> (retire_cycles == `IDT_CYC_TWO))
    else $error("double-word instruction not two cycles");
  chk_second_word_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (fld_second && take && (fetch_word[`IDT_OPC_HI:`IDT_OPC_LO] != 8'h00))
      |=> (dec_invalid && !pc_load))
    else $error("second word with nonzero top byte accepted");
  chk_stray_word_nop: assert property (@(posedge pclk) disable iff (!presetn)
    ((s_r.st == st_fetch) && take && !s_r.skip_pend
      && (fetch_word[`IDT_OPC_HI:`IDT_OPC_LO] == 8'h00))
      |=> (dec_valid && (dec_class == cl_nop) && !pc_load && (retire_cycles == `IDT_CYC_ONE)))
    else $error("stray second word did not act as nop");
  chk_fill_is_nop: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.st == st_fill) |-> (nop_fill && !fetch_ready) ##1 (retire && !nop_fill))
    else $error("extra cycle not filled by nop");
  chk_skip_cycle_count: assert property (@(posedge pclk) disable iff (!presetn)
    ((s_r.st == st_fetch) && take && s_r.skip_pend && !f_dbl)
      |=> (retire && (retire_class == cl_skip)
        && (retire_cycles == 2'($past(s_r.skip_cnt) + 2'h1))))
    else $error("skip cycle count wrong");
  chk_move_two_cycles: assert property (@(posedge pclk) disable iff (!presetn)
    (retire && (retire_class == cl_movd)) |-> (retire_cycles == `IDT_CYC_TWO))
    else $error("double-word move not two cycles");
  chk_single_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    (retire && ((retire_class == cl_alu) || (retire_class == cl_lit)))
      |-> (retire_cycles == `IDT_CYC_ONE))
    else $error("plain single-word instruction not one cycle");
  chk_prog_addr_even: assert property (@(posedge pclk) disable iff (!presetn)
    pc_load |-> !dec_prog_addr[0])
    else $error("odd program address loaded");
  chk_byte_literal: assert property (@(posedge pclk) disable iff (!presetn)
    (dec_valid && (dec_class == cl_lit) && (dec_size == sz_byte) && !dec_invalid)
      |-> (dec_lit <= 16'h00ff))
    else $error("byte literal above 255 accepted");
  chk_signed_extend: assert property (@(posedge pclk) disable iff (!presetn)
    (dec_valid && (dec_class == cl_slit)) |-> (dec_lit[15:10] == {6{dec_lit[9]}}))
    else $error("signed literal not sign-extended");
  chk_writeback_step: assert property (@(posedge pclk) disable iff (!presetn)
    (dec_valid && (dec_class == cl_mac)) |-> (dec_w13_step == (dec_wb_ind ? 3'h2 : 3'h0)))
    else $error("writeback post-increment wrong");
endmodule

// file: idt_defines.svh
`ifndef IDT_DEFINES_SVH
`define IDT_DEFINES_SVH
`define IDT_OFS_CTRL 8'h00
`define IDT_OFS_STATUS 8'h04
`define IDT_OFS_COUNT 8'h08
`define IDT_OFS_LAST 8'h0c
`define IDT_CTRL_EN_RST 1'b1
`define IDT_CTRL_WIN_RST 1'b0
`define IDT_CTRL_EN_BIT 0
`define IDT_CTRL_WIN_BIT 1
`define IDT_STAT_DSP_HI 8
`define IDT_STAT_DSP_LO 5
`define IDT_OPC_HI 23
`define IDT_OPC_LO 16
`define IDT_SIZE_HI 15
`define IDT_SIZE_LO 14
`define IDT_MODE_HI 13
`define IDT_MODE_LO 11
`define IDT_DREG_HI 10
`define IDT_DREG_LO 7
`define IDT_BREG_HI 6
`define IDT_BREG_LO 3
`define IDT_LIT_HI 13
`define IDT_LIT_LO 4
`define IDT_BIT_HI 15
`define IDT_BIT_LO 12
`define IDT_FILE_HI 12
`define IDT_ACC_BIT 15
`define IDT_WB_BIT 14
`define IDT_PADR_HI 6
`define IDT_OP_NOP 8'h00
`define IDT_OP_CALL 8'h02
`define IDT_OP_GOTO 8'h04
`define IDT_OP_BRA 8'h30
`define IDT_OP_ALU 8'h40
`define IDT_OP_PSVRD 8'h90
`define IDT_OP_SKIP 8'ha6
`define IDT_OP_BITOP 8'ha8
`define IDT_OP_LIT 8'hb0
`define IDT_OP_SLIT 8'hb1
`define IDT_OP_TBLRD 8'hba
`define IDT_OP_MOVD 8'hbe
`define IDT_OP_FILERD 8'hbf
`define IDT_OP_MAC 8'hc0
`define IDT_SPECIAL_LIMIT 13'h1000
`define IDT_BYTE_LIT_MAX 10'h0ff
`define IDT_W13_STEP 3'h2
`define IDT_CYC_ONE 2'h1
`define IDT_CYC_TWO 2'h2
`define IDT_CYC_THREE 2'h3
`endif

// file: idt_pkg.sv
package idt_pkg;
  typedef enum logic [1:0] {st_fetch = 2'b00, st_second = 2'b01, st_fill = 2'b10} idt_state_t;
  typedef enum logic [3:0] {
    cl_nop = 4'b0000, cl_goto = 4'b0001, cl_call = 4'b0010, cl_bra = 4'b0011,
    cl_skip = 4'b0100, cl_movd = 4'b0101, cl_tblrd = 4'b0110, cl_filerd = 4'b0111,
    cl_psvrd = 4'b1000, cl_lit = 4'b1001, cl_slit = 4'b1010, cl_mac = 4'b1011,
    cl_bitop = 4'b1100, cl_alu = 4'b1101, cl_invalid = 4'b1111
  } idt_class_t;
  typedef enum logic [1:0] {sz_word = 2'b00, sz_byte = 2'b01, sz_dword = 2'b10,
                            sz_rsvd = 2'b11} idt_size_t;
  typedef enum logic [2:0] {
    md_direct = 3'b000, md_indirect = 3'b001, md_postinc = 3'b010, md_postdec = 3'b011,
    md_preinc = 3'b100, md_predec = 3'b101, md_offset = 3'b110, md_rsvd = 3'b111
  } idt_mode_t;
  typedef struct packed {
    logic second_accum_clamp_flag;
    logic first_accum_clamp_flag;
    logic second_accum_overflow_flag;
    logic first_accum_overflow_flag;
    logic zero_flag;
    logic signed_wrap_flag;
    logic negative_flag;
    logic digit_carry_flag;
    logic carry_flag;
  } idt_flag_t;
  typedef struct packed {
    idt_state_t st;
    logic skip_pend;
    logic [1:0] skip_cnt;
    logic [23:0] w1;
    logic en;
    logic win_en;
    logic [15:0] instr_cnt;
    logic [31:0] prdata;
    logic dec_valid;
    idt_class_t dec_class;
    idt_size_t dec_size;
    logic [15:0] dec_lit;
    logic [12:0] dec_file_addr;
    logic [3:0] dec_bit_pos;
    logic [3:0] dec_base_reg;
    logic [3:0] dec_dst_reg;
    idt_mode_t dec_dst_mode;
    logic dec_acc_sel;
    logic dec_wb_ind;
    logic [2:0] dec_w13_step;
    logic [22:0] dec_prog_addr;
    logic dec_invalid;
    logic pc_load;
    logic nop_fill;
    logic retire;
    idt_class_t ret_class;
    logic [1:0] ret_cycles;
    idt_class_t pend_class;
  } idt_top_t;
endpackage

// file: idt_fields.sv
`timescale 1ns/1ns
`include "idt_defines.svh"
module idt_fields (
  input wire logic [23:0] w1,
  input wire logic [23:0] w2,
  input wire logic second,
  output idt_pkg::idt_class_t cls,
  output logic dbl,
  output idt_pkg::idt_size_t size,
  output logic [15:0] lit,
  output logic [12:0] file_addr,
  output logic [3:0] bit_pos,
  output logic [3:0] base_reg,
  output logic [3:0] dst_reg,
  output idt_pkg::idt_mode_t dst_mode,
  output logic acc_sel,
  output logic wb_ind,
  output logic [22:0] prog_addr,
  output logic invalid
);
  import idt_pkg::*;
  logic [9:0] lit_raw;
  always_comb begin
    unique case (w1[`IDT_OPC_HI:`IDT_OPC_LO])
      `IDT_OP_NOP: cls = cl_nop;
      `IDT_OP_GOTO: cls = cl_goto;
      `IDT_OP_CALL: cls = cl_call;
      `IDT_OP_BRA: cls = cl_bra;
      `IDT_OP_SKIP: cls = cl_skip;
      `IDT_OP_MOVD: cls = cl_movd;
      `IDT_OP_TBLRD: cls = cl_tblrd;
      `IDT_OP_FILERD: cls = cl_filerd;
      `IDT_OP_PSVRD: cls = cl_psvrd;
      `IDT_OP_LIT: cls = cl_lit;
      `IDT_OP_SLIT: cls = cl_slit;
      `IDT_OP_MAC: cls = cl_mac;
      `IDT_OP_BITOP: cls = cl_bitop;
      `IDT_OP_ALU: cls = cl_alu;
      default: cls = cl_invalid;
    endcase
    dbl = (cls == cl_goto) || (cls == cl_call);
    size = idt_size_t'(w1[`IDT_SIZE_HI:`IDT_SIZE_LO]);
    lit_raw = w1[`IDT_LIT_HI:`IDT_LIT_LO];
    lit = (cls == cl_slit) ? {{6{lit_raw[9]}}, lit_raw} : {6'h00, lit_raw};
    file_addr = w1[`IDT_FILE_HI:0];
    bit_pos = w1[`IDT_BIT_HI:`IDT_BIT_LO];
    base_reg = w1[`IDT_BREG_HI:`IDT_BREG_LO];
    dst_reg = w1[`IDT_DREG_HI:`IDT_DREG_LO];
    dst_mode = idt_mode_t'(w1[`IDT_MODE_HI:`IDT_MODE_LO]);
    acc_sel = w1[`IDT_ACC_BIT];
    wb_ind = w1[`IDT_WB_BIT];
    prog_addr = {w2[`IDT_PADR_HI:0], w1[15:0]};
    invalid = (cls == cl_invalid)
      || (((cls == cl_lit) || (cls == cl_alu)) && (size == sz_rsvd))
      || ((cls == cl_lit) && (size == sz_byte) && (lit_raw > `IDT_BYTE_LIT_MAX))
      || ((cls == cl_alu) && (dst_mode == md_rsvd))
      || (second && (w2[`IDT_OPC_HI:`IDT_OPC_LO] != 8'h00))
      || (second && dbl && prog_addr[0]);
  end
endmodule

// file: idt_flags.sv
`timescale 1ns/1ns
module idt_flags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic alu_upd,
  input wire logic alu_carry,
  input wire logic alu_digit_carry,
  input wire logic alu_negative,
  input wire logic alu_signed_wrap,
  input wire logic alu_zero,
  input wire logic alu_sticky_z,
  input wire logic acc_a_ovf,
  input wire logic acc_b_ovf,
  input wire logic acc_a_sat,
  input wire logic acc_b_sat,
  input wire logic [3:0] dsp_clr,
  output idt_pkg::idt_flag_t flags
);
  import idt_pkg::*;
  idt_flag_t flags_r;
  idt_flag_t flags_nxt;
  always_comb begin
    flags_nxt = flags_r;
    if (alu_upd) begin
      flags_nxt.carry_flag = alu_carry;
      flags_nxt.digit_carry_flag = alu_digit_carry;
      flags_nxt.negative_flag = alu_negative;
      flags_nxt.signed_wrap_flag = alu_signed_wrap;
      flags_nxt.zero_flag = alu_sticky_z ? (flags_r.zero_flag & alu_zero) : alu_zero;
    end
    // Clear first, then set, so an event in the clearing cycle survives.
    flags_nxt.first_accum_overflow_flag = (flags_r.first_accum_overflow_flag & ~dsp_clr[0])
      | acc_a_ovf;
    flags_nxt.second_accum_overflow_flag = (flags_r.second_accum_overflow_flag & ~dsp_clr[1])
      | acc_b_ovf;
    flags_nxt.first_accum_clamp_flag = (flags_r.first_accum_clamp_flag & ~dsp_clr[2])
      | acc_a_sat;
    flags_nxt.second_accum_clamp_flag = (flags_r.second_accum_clamp_flag & ~dsp_clr[3])
      | acc_b_sat;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end
  assign flags = flags_r;
  chk_zero_sticky_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (alu_upd && alu_sticky_z && !alu_zero) |=> !flags.zero_flag)
    else $error("sticky zero flag not cleared by nonzero result");
  chk_accum_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_a_ovf && dsp_clr[0]) or (acc_b_sat && dsp_clr[3]) |=>
      (flags.first_accum_overflow_flag || flags.second_accum_clamp_flag))
    else $error("accumulator flag event lost to clear");
endmodule

// file: idt_fetch_model.sv
`timescale 1ns/1ns
// ***
// Program memory fetch side
// ***
module idt_fetch_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [23:0] push_word,
  input wire logic stall,
  input wire logic fetch_ready,
  output logic fetch_valid,
  output logic [23:0] fetch_word
);
  logic [23:0] q[$];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.delete();
      fetch_valid <= 1'h0;
      fetch_word <= 24'h0;
    end else begin
      if (fetch_valid && fetch_ready) void'(q.pop_front());
      if (push) q.push_back(push_word);
      // A stall only delays a new offer; a pending offer is never withdrawn.
      if (q.size() > 0 && ((fetch_valid && !fetch_ready) || !stall)) begin
        fetch_valid <= 1'h1;
        fetch_word <= q[0];
      end else begin
        fetch_valid <= 1'h0;
        fetch_word <= ~fetch_word;
      end
    end
  end
endmodule

// file: tb.sv
`timescale 1ns/1ns
`include "idt_defines.svh"
// ***
// Bench
// ***
module tb;
  import idt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, win, push, stall;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, rs, sd;
  logic [23:0] push_word, fetch_word;
  logic fetch_valid, fetch_ready, cond_true, skip_test, alu_upd, alu_carry, alu_digit_carry;
  logic alu_negative, alu_signed_wrap, alu_zero, alu_sticky_z;
  logic acc_a_ovf, acc_b_ovf, acc_a_sat, acc_b_sat;
  idt_class_t dec_class, retire_class;
  idt_size_t dec_size;
  idt_mode_t dec_dst_mode;
  logic [15:0] dec_lit;
  logic [12:0] dec_file_addr;
  logic [3:0] dec_bit_pos, dec_base_reg, dec_dst_reg;
  logic [2:0] dec_w13_step;
  logic [22:0] dec_prog_addr;
  logic [1:0] retire_cycles;
  logic dec_valid, dec_acc_sel, dec_wb_ind, dec_invalid, pc_load, nop_fill, retire;
  int bad_count, samples_checked, nfc, nfm, pcc, cnt;
  idt_decoder dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fetch_valid, .fetch_word, .fetch_ready, .cond_true, .skip_test,
    .alu_upd, .alu_carry, .alu_digit_carry, .alu_negative, .alu_signed_wrap, .alu_zero,
    .alu_sticky_z, .acc_a_ovf, .acc_b_ovf, .acc_a_sat, .acc_b_sat, .dec_valid, .dec_class,
    .dec_size, .dec_lit, .dec_file_addr, .dec_bit_pos, .dec_base_reg, .dec_dst_reg,
    .dec_dst_mode, .dec_acc_sel, .dec_wb_ind, .dec_w13_step, .dec_prog_addr, .dec_invalid,
    .pc_load, .nop_fill, .retire, .retire_class, .retire_cycles);
  idt_fetch_model fm (.pclk, .presetn, .push, .push_word, .stall, .fetch_ready,
    .fetch_valid, .fetch_word);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Reference cycle count of a single word.
  function automatic int ecyc(input logic [23:0] w);
    case (w[23:16])
      `IDT_OP_TBLRD, `IDT_OP_MOVD: return 2;
      `IDT_OP_BRA: return cond_true ? 2 : 1;
      `IDT_OP_FILERD: return w[12:0] < 13'h1000 ? 2 : 1;
      `IDT_OP_PSVRD: return win ? 2 : 1;
      default: return 1;
    endcase
  endfunction
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    sd = lfsr(sd);
    stall <= sd[0];
  end
  // Sampled on the falling edge so the counts never race the checking tasks.
  always @(negedge pclk) begin
    nfc += (nop_fill === 1'h1);
    pcc += (pc_load === 1'h1);
  end
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task put(input logic [23:0] w);
    @(posedge pclk);
    push <= 1'h1;
    push_word <= w;
  endtask
  task fin(input logic [3:0] cl, input int cy, input int nf);
    int k;
    k = 0;
    @(posedge pclk);
    push <= 1'h0;
    while (retire !== 1'h1 && k < 40) begin
      @(posedge pclk);
      k++;
    end
    chk("retire", 1, retire);
    if (cl != 4'he) chk("class", cl, retire_class);
    chk("cycles", cy, retire_cycles);
    chk("fills", nf, nfc - nfm);
    nfm = nfc;
    cnt++;
  endtask
  task one(input logic [23:0] w, input logic [3:0] cl);
    put(w);
    fin(cl, ecyc(w), ecyc(w) - 1);
  endtask
  task flg(input logic [6:0] v);
    @(posedge pclk);
    {alu_upd, alu_carry, alu_digit_carry, alu_negative, alu_signed_wrap, alu_zero,
      alu_sticky_z} <= v;
    @(posedge pclk);
    alu_upd <= 1'h0;
    apb(0, `IDT_OFS_STATUS, 0);
  endtask
  task stop_test;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    $display("Error watchdog expected done seen hang");
    stop_test;
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, win, push, stall, push_word} = '0;
    {cond_true, skip_test, alu_upd, alu_carry, alu_digit_carry, alu_negative} = '0;
    {alu_signed_wrap, alu_zero, alu_sticky_z, acc_a_ovf, acc_b_ovf, acc_a_sat, acc_b_sat} = '0;
    {bad_count, samples_checked, nfc, nfm, pcc, cnt} = '0;
    rs = 32'h324c66ee;
    sd = 32'h324c66ee;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(0, `IDT_OFS_CTRL, 0);
    chk("ctrl", 1, rd);
    apb(0, 8'h40, 0);
    chk("slverr", 1, er);
    for (int i = 0; i < 7; i++) begin
      rs = lfsr(rs);
      one({`IDT_OP_ALU, 2'(i % 3), 3'(i), rs[10:0]}, cl_alu);
      chk("mode", i, dec_dst_mode);
      chk("size", i % 3, dec_size);
      chk("regs", rs[10:3], {dec_dst_reg, dec_base_reg});
    end
    one({`IDT_OP_ALU, 2'h0, 3'h7, 11'h0}, cl_alu);
    chk("inv", 1, dec_invalid);
    $display("test fields done");
    one({`IDT_OP_LIT, 2'h0, 10'h3ff, 4'h0}, cl_lit);
    chk("lit", 16'h03ff, dec_lit);
    one({`IDT_OP_LIT, 2'h1, 10'h0ff, 4'h0}, cl_lit);
    chk("lit", 16'h00ff, dec_lit);
    one({`IDT_OP_LIT, 2'h1, 10'h100, 4'h0}, cl_lit);
    chk("inv", 1, dec_invalid);
    one({`IDT_OP_SLIT, 2'h0, 10'h200, 4'h0}, cl_slit);
    chk("slit", 16'hfe00, dec_lit);
    one({`IDT_OP_BITOP, 4'hf, 12'h0}, cl_bitop);
    chk("bit", 4'hf, dec_bit_pos);
    one({`IDT_OP_FILERD, 3'h0, 13'h1fff}, cl_filerd);
    chk("file", 13'h1fff, dec_file_addr);
    one({`IDT_OP_FILERD, 16'h0ff0}, cl_filerd);
    one({`IDT_OP_MAC, 2'h3, 14'h0}, cl_mac);
    chk("mac", 5'h0b, {dec_w13_step, dec_acc_sel, dec_wb_ind});
    one({`IDT_OP_MAC, 16'h0}, cl_mac);
    chk("mac", 5'h00, {dec_w13_step, dec_acc_sel, dec_wb_ind});
    one({`IDT_OP_TBLRD, 16'h0}, cl_tblrd);
    one({`IDT_OP_MOVD, 16'h0}, cl_movd);
    one({`IDT_OP_BRA, 16'h0}, cl_bra);
    cond_true <= 1'h1;
    one({`IDT_OP_BRA, 16'h0}, cl_bra);
    cond_true <= 1'h0;
    one({`IDT_OP_PSVRD, 16'h0}, cl_psvrd);
    apb(1, `IDT_OFS_CTRL, 3);
    win = 1'h1;
    one({`IDT_OP_PSVRD, 16'h0}, cl_psvrd);
    $display("test timing done");
    put({`IDT_OP_GOTO, 16'h1234});
    put(24'h000056);
    fin(cl_goto, 2, 0);
    chk("addr", 23'h561234, dec_prog_addr);
    put({`IDT_OP_CALL, 16'h1235});
    put(24'h000000);
    fin(4'he, 2, 0);
    chk("inv", 1, dec_invalid);
    put({`IDT_OP_GOTO, 16'h1234});
    put(24'h010000);
    fin(4'he, 2, 0);
    chk("inv", 1, dec_invalid);
    one(24'h001234, cl_nop);
    chk("inv", 0, dec_invalid);
    skip_test <= 1'h1;
    put({`IDT_OP_SKIP, 16'h0});
    put({`IDT_OP_ALU, 16'h0});
    fin(cl_skip, 2, 1);
    put({`IDT_OP_SKIP, 16'h0});
    put({`IDT_OP_GOTO, 16'h0100});
    put(24'h000000);
    fin(cl_skip, 3, 2);
    skip_test <= 1'h0;
    chk("pcload", 1, pcc);
    $display("test flow done");
    flg(7'b1111110);
    chk("status", 32'h1f, rd);
    flg(7'b1000001);
    flg(7'b1000011);
    chk("status", 32'h0, rd);
    flg(7'b1000010);
    chk("status", 32'h10, rd);
    @(posedge pclk);
    {acc_a_ovf, acc_b_ovf, acc_a_sat, acc_b_sat} <= 4'b1001;
    @(posedge pclk);
    acc_b_sat <= 1'h0;
    apb(0, `IDT_OFS_STATUS, 0);
    chk("dsp", 32'h130, rd);
    apb(1, `IDT_OFS_STATUS, 32'h1e0);
    apb(0, `IDT_OFS_STATUS, 0);
    chk("dsp", 32'h30, rd);
    apb(0, `IDT_OFS_COUNT, 0);
    chk("count", cnt, rd);
    $display("test flags done");
    stop_test;
  end
endmodule
